// ===== psq_map.svh
// Register offsets, field positions, reset values and timing counts of the power sequencer.
// Assumes a 25 MHz system clock and a 32-bit APB register port.
`ifndef PSQ_MAP_SVH
`define PSQ_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PSQ_GEN_OFF 8'h00
`define PSQ_SLOT_OFF 8'h04
`define PSQ_BUCK_OFF 8'h08
`define PSQ_EN_OFF 8'h0C
`define PSQ_POL_OFF 8'h10
`define PSQ_STAT_OFF 8'h14
`define PSQ_FLAG_OFF 8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PSQ_GEN_STEP_BIT 4
`define PSQ_EN_MODE_BIT 6
`define PSQ_EN_BANK_BIT 7
`define PSQ_POL_THERMAL_RESTART_POLICY_LO 6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PSQ_SLOT_RST 18'h358C8
`define PSQ_BUCK_RST 12'h513
`define PSQ_EN_RST 8'h80
`define PSQ_POL_RST 8'h3F

// ----------------------------------------------------------------------------
// Timing: figures and derived cycle counts at 25 MHz
// ----------------------------------------------------------------------------
`define PSQ_CLK_MHZ 25
`define PSQ_TICK_US 128
`define PSQ_TICK_CYC (`PSQ_TICK_US * `PSQ_CLK_MHZ)
`define PSQ_BLANK_US 50
`define PSQ_BLANK_CYC (`PSQ_BLANK_US * `PSQ_CLK_MHZ)
`define PSQ_BIAS_US 32
`define PSQ_BIAS_CYC (`PSQ_BIAS_US * `PSQ_CLK_MHZ)
`define PSQ_STEP_FAST_NS 2670
`define PSQ_STEP_FAST_CYC ((`PSQ_STEP_FAST_NS * `PSQ_CLK_MHZ) / 1000)
`define PSQ_STEP_SLOW_NS 10670
`define PSQ_STEP_SLOW_CYC ((`PSQ_STEP_SLOW_NS * `PSQ_CLK_MHZ) / 1000)
`define PSQ_PG_TICKS 16
`define PSQ_SEQ_TICKS 8

`endif

// ===== psq_pkg.sv
// Types shared by the power sequencer: state encoding and carried signal groups.
// Assumes psq_map.svh for all numbers.
package psq_pkg;
    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        PSQ_OFF = 5'h01,
        PSQ_BIAS = 5'h02,
        PSQ_DELAY = 5'h04,
        PSQ_UP = 5'h08,
        PSQ_DOWN = 5'h10
    } psq_state_t;

    // Live status inputs from analog monitors
    typedef struct packed {
        logic thermal_shutdown;
        logic warn;
        logic undervoltage_lockout;
    } psq_mon_t;

    // Outputs steering the analog regulators
    typedef struct packed {
        logic [5:0] rail_en;
        logic [5:0] discharge;
        logic buck_pwm;
        logic [4:0] buck_ref;
    } psq_ctl_t;
endpackage

// ===== psq_ctrl.sv
// Power sequencer control: hardware-enable sequencing, buck ramp, status and flags, APB regs.
// Assumes an APB master on sys_clk_i, asynchronous pins synchronised here, analog beyond.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "psq_map.svh"

module psq_ctrl (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic hw_enable_pin_i,
    input wire psq_pkg::psq_mon_t mon_i,
    input wire logic bus_present_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output psq_pkg::psq_ctl_t ctl_o
);
    import psq_pkg::*;

    // ------------------------------------------------------------------------
    // Synchronisers and edges
    // ------------------------------------------------------------------------
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic en_d_r;
    logic [3:0] src_d_r;
    logic en_s;
    logic en_rise;
    logic en_fall;
    logic [3:0] src_s;

    // Two-flop capture of enable pin, monitor and bus presence levels
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_r <= 5'h10; // Bus counted present until sampled
            sync2_r <= 5'h10;
        end else begin
            sync1_r <= {bus_present_i, mon_i, hw_enable_pin_i};
            sync2_r <= sync1_r;
        end
    end

    assign en_s = sync2_r[0];
    assign en_rise = en_s & ~en_d_r;
    assign en_fall = ~en_s & en_d_r;

    // ------------------------------------------------------------------------
    // Tick counter and sequencer
    // ------------------------------------------------------------------------
    psq_state_t state_r;
    logic [11:0] tick_cnt_r;
    logic tick;
    logic [11:0] blank_cnt_r;
    logic blank;
    logic [3:0] step_r;
    logic [4:0] pg_cnt_r;
    logic pg_r;
    logic pus_done;
    logic soft_rst;
    logic [17:0] slot_r;
    logic [7:0] en_r;
    logic [7:0] pol_r;
    logic step_sel_r;
    logic [11:0] buck_r;
    logic [5:0] rail_r;
    logic [5:0] dis_r;
    logic [5:0] seq_on;

    assign tick = (tick_cnt_r == 12'(`PSQ_TICK_CYC - 1));

    // 128 us tick, restarted on enable rise, shared by the sequencer and power-good delays
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt_r <= 12'h000;
        end else if (tick || en_rise) begin
            tick_cnt_r <= 12'h000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 12'h001;
        end
    end

    // Slot i compares its 3-bit code against the tick step
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_slot
            assign seq_on[gi] = (step_r > {1'b0, slot_r[gi*3 +: 3]});
        end
    endgenerate

    assign pus_done = (state_r == PSQ_UP) && (step_r == 4'(`PSQ_SEQ_TICKS));

    // Sequencer state and tick step
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= PSQ_OFF;
            step_r <= 4'h0;
            en_d_r <= 1'b0;
        end else begin
            en_d_r <= en_s;
            case (state_r)
                PSQ_OFF: begin
                    if (en_rise) begin
                        state_r <= PSQ_BIAS;
                        step_r <= 4'h0;
                    end
                end
                PSQ_BIAS: begin
                    if (en_fall) begin
                        state_r <= PSQ_OFF;
                    end else if (tick) begin
                        state_r <= PSQ_DELAY;
                        step_r <= 4'h0;
                    end
                end
                PSQ_DELAY: begin
                    if (en_fall) begin
                        state_r <= PSQ_OFF;
                    end else if (tick && step_r >= {1'b0, pol_r[2:0]}) begin
                        state_r <= PSQ_UP;
                        step_r <= 4'h0;
                    end else if (tick) begin
                        step_r <= step_r + 4'h1;
                    end
                end
                PSQ_UP: begin
                    if (en_fall) begin
                        state_r <= PSQ_DOWN;
                        step_r <= 4'(`PSQ_SEQ_TICKS);
                    end else if (tick && !pus_done) begin
                        step_r <= step_r + 4'h1;
                    end
                end
                PSQ_DOWN: begin
                    if (en_rise) begin
                        state_r <= PSQ_BIAS;
                        step_r <= 4'h0;
                    end else if (tick && step_r == 4'h0) begin
                        state_r <= PSQ_OFF;
                    end else if (tick) begin
                        step_r <= step_r - 4'h1;
                    end
                end
                default: state_r <= PSQ_OFF;
            endcase
        end
    end

    // Blanking window after enable: bus refused for 50 us
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            blank_cnt_r <= 12'h000;
        end else if (en_rise) begin
            blank_cnt_r <= 12'(`PSQ_BLANK_CYC);
        end else if (blank_cnt_r != 12'h000) begin
            blank_cnt_r <= blank_cnt_r - 12'h001;
        end
    end
    assign blank = (blank_cnt_r != 12'h000);

    // Rail enables: sequence slots in power up, register enables override after
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rail_r <= 6'h00;
            dis_r <= 6'h3F;
        end else begin
            case (state_r)
                PSQ_UP: begin
                    rail_r <= seq_on & en_r[5:0];
                    dis_r <= ~(seq_on & en_r[5:0]) & pol_r[5:0];
                end
                PSQ_DOWN: begin
                    rail_r <= rail_r & seq_on;
                    dis_r <= 6'h3F;
                end
                PSQ_DELAY: begin
                    rail_r <= 6'h00;
                    dis_r <= 6'h3F;
                end
                default: begin
                    rail_r <= 6'h00;
                    dis_r <= 6'h3F;
                end
            endcase
        end
    end

    // Power-good: low during sequence plus 16 ticks, then high
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pg_cnt_r <= 5'h00;
            pg_r <= 1'b0;
        end else if (!pus_done) begin
            pg_cnt_r <= 5'h00;
            pg_r <= 1'b0;
        end else if (tick && pg_cnt_r != 5'(`PSQ_PG_TICKS)) begin
            pg_cnt_r <= pg_cnt_r + 5'h01;
        end else if (pg_cnt_r == 5'(`PSQ_PG_TICKS)) begin
            pg_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Buck reference ramp
    // ------------------------------------------------------------------------
    logic [9:0] ramp_cnt_r;
    logic [4:0] ref_r;
    logic [4:0] target;
    logic [9:0] step_len;
    logic buck_wait;
    logic [9:0] bias_cnt_r;

    assign target = en_r[`PSQ_EN_BANK_BIT] ? buck_r[4:0] : buck_r[10:6];
    assign step_len = step_sel_r ? 10'(`PSQ_STEP_SLOW_CYC) : 10'(`PSQ_STEP_FAST_CYC);

    // Buck bias delay before the reference may leave zero
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bias_cnt_r <= 10'h000;
        end else if (!rail_r[0]) begin
            bias_cnt_r <= 10'h000;
        end else if (bias_cnt_r != 10'(`PSQ_BIAS_CYC)) begin
            bias_cnt_r <= bias_cnt_r + 10'h001;
        end
    end
    assign buck_wait = (bias_cnt_r != 10'(`PSQ_BIAS_CYC));

    // One step per step time, both directions
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ramp_cnt_r <= 10'h000;
            ref_r <= 5'h00;
        end else if (buck_wait) begin
            ramp_cnt_r <= 10'h000;
            ref_r <= 5'h00;
        end else if (ramp_cnt_r < step_len - 10'h001) begin
            ramp_cnt_r <= ramp_cnt_r + 10'h001;
        end else begin
            ramp_cnt_r <= 10'h000;
            if (ref_r < target) begin
                ref_r <= ref_r + 5'h01;
            end else if (ref_r > target) begin
                ref_r <= ref_r - 5'h01;
            end
        end
    end

    // Regulator control group, one driver for the whole struct
    assign ctl_o = {rail_r, dis_r, en_r[`PSQ_EN_MODE_BIT], ref_r};

    // ------------------------------------------------------------------------
    // Interrupt flags and APB registers
    // ------------------------------------------------------------------------
    logic [3:0] flag_r;
    logic [3:0] src;
    logic wr;
    logic rd;
    logic rd_flag;
    logic [3:0] flag_clr;

    assign src = {src_s[3:1], pg_r}; // tsd, warn, undervoltage_lockout, power-good
    assign src_s = {sync2_r[3:1], 1'b0};
    assign wr = psel_i & penable_i & pwrite_i & ~blank;
    assign rd = psel_i & penable_i & ~pwrite_i & ~blank;
    assign rd_flag = rd && (paddr_i == `PSQ_FLAG_OFF);
    assign soft_rst = (!en_s && !sync2_r[4])
        || (sync2_r[3] && !src_d_r[3] && pol_r[7:`PSQ_POL_THERMAL_RESTART_POLICY_LO] == 2'b00)
        || sync2_r[1];
    // A read clears only the flags it returned, so a later event is not lost
    assign flag_clr = en_rise ? 4'hF : (rd_flag ? prdata_o[3:0] : 4'h0);

    // Dual edge detect; set beats clear
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src_d_r <= 4'h0;
            flag_r <= 4'h0;
        end else begin
            src_d_r <= src;
            flag_r <= (flag_r & ~flag_clr) | (src ^ src_d_r);
        end
    end

    // Writable configuration; defaults forced on undervoltage, thermal shutdown with policy 00, or enable low with bus absent
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slot_r <= `PSQ_SLOT_RST;
            buck_r <= `PSQ_BUCK_RST;
            en_r <= `PSQ_EN_RST;
            pol_r <= `PSQ_POL_RST;
            step_sel_r <= 1'b0;
        end else if (soft_rst) begin
            slot_r <= `PSQ_SLOT_RST;
            buck_r <= `PSQ_BUCK_RST;
            en_r <= `PSQ_EN_RST;
            pol_r <= `PSQ_POL_RST;
            step_sel_r <= 1'b0;
        end else if (wr) begin
            case (paddr_i)
                `PSQ_GEN_OFF: step_sel_r <= pwdata_i[`PSQ_GEN_STEP_BIT];
                `PSQ_SLOT_OFF: slot_r <= pwdata_i[17:0];
                `PSQ_BUCK_OFF: buck_r <= pwdata_i[11:0];
                `PSQ_EN_OFF: en_r <= pwdata_i[7:0];
                `PSQ_POL_OFF: pol_r <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    // Read data register and error answer
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_o <= 32'h00000000;
        end else if (psel_i && !penable_i) begin
            case (paddr_i)
                `PSQ_GEN_OFF: prdata_o <= 32'({step_sel_r, 4'h0});
                `PSQ_SLOT_OFF: prdata_o <= 32'(slot_r);
                `PSQ_BUCK_OFF: prdata_o <= 32'(buck_r);
                `PSQ_EN_OFF: prdata_o <= 32'(en_r);
                `PSQ_POL_OFF: prdata_o <= 32'(pol_r);
                `PSQ_STAT_OFF: prdata_o <= 32'({rail_r, src});
                `PSQ_FLAG_OFF: prdata_o <= 32'(flag_r);
                default: prdata_o <= 32'h00000000;
            endcase
        end
    end

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & (blank | (paddr_i > `PSQ_FLAG_OFF)
        | (paddr_i[1:0] != 2'b00));
endmodule // psq_ctrl

// ===== psq_ctrl_asserts.sv
// Checker: timing relations at the power sequencer ports.
// Assumes binding to psq_ctrl, one 25 MHz clock domain.
`timescale 1ns/1ps
module psq_ctrl_asserts
    import psq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic hw_enable_pin_i,
    input wire psq_pkg::psq_mon_t mon_i,
    input wire logic bus_present_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire psq_pkg::psq_ctl_t ctl_o
);
    logic [15:0] rise_cnt_r;
    logic [9:0] gap_cnt_r;
    logic [5:0] rail_prev_r;
    logic [4:0] ref_prev_r;
    logic en_prev_r, pwm_want_r;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // Cycles since the enable pin rose, saturating
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rise_cnt_r <= 16'hFFFF;
            en_prev_r <= 1'b0;
        end else begin
            en_prev_r <= hw_enable_pin_i;
            if (hw_enable_pin_i && !en_prev_r) rise_cnt_r <= 16'h0000;
            else if (rise_cnt_r != 16'hFFFF) rise_cnt_r <= rise_cnt_r + 16'h0001;
        end
    end
    // Previous outputs and cycles since the last reference step
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rail_prev_r <= 6'h00;
            ref_prev_r <= 5'h00;
            gap_cnt_r <= 10'h3FF;
            pwm_want_r <= 1'b0;
        end else begin
            rail_prev_r <= ctl_o.rail_en;
            ref_prev_r <= ctl_o.buck_ref;
            pwm_want_r <= pwdata_i[6];
            if (ctl_o.buck_ref != ref_prev_r) gap_cnt_r <= 10'h000;
            else if (gap_cnt_r != 10'h3FF) gap_cnt_r <= gap_cnt_r + 10'h001;
        end
    end
    a_bias_first: assert property (rise_cnt_r < 16'd6000 |-> ctl_o.rail_en == 6'h00)
        else $error("rail on before bias and delay");
    a_blank_nack: assert property (rise_cnt_r >= 16'd4 && rise_cnt_r <= 16'd1240
        && psel_i && penable_i |-> pslverr_o) else $error("access taken in blanking");
    a_discharge_all: assert property (rise_cnt_r >= 16'd3300 && rise_cnt_r <= 16'd6300
        |-> ctl_o.discharge == 6'h3F) else $error("discharge off in delay slot");
    a_rail_up: assert property (hw_enable_pin_i && ctl_o.rail_en != rail_prev_r
        |-> ctl_o.rail_en == {rail_prev_r[4:0], 1'b1}) else $error("rail order on");
    a_rail_down: assert property (!hw_enable_pin_i && ctl_o.rail_en != rail_prev_r
        |-> ctl_o.rail_en == {1'b0, rail_prev_r[5:1]}) else $error("rail order off");
    a_ref_unit: assert property (ctl_o.buck_ref != ref_prev_r |->
        ctl_o.buck_ref == ref_prev_r + 5'd1 || ctl_o.buck_ref == ref_prev_r - 5'd1)
        else $error("reference jump");
    a_step_gap: assert property (ctl_o.buck_ref != ref_prev_r |-> gap_cnt_r >= 10'd60)
        else $error("reference step too soon");
    a_bad_addr: assert property (psel_i && penable_i &&
        (paddr_i > 8'h18 || paddr_i[1:0] != 2'b00) |-> pslverr_o) else $error("bad address ok");
    a_pwm_bit: assert property (psel_i && penable_i && pwrite_i && paddr_i == 8'h0C
        && !pslverr_o |=> ctl_o.buck_pwm == pwm_want_r) else $error("mode bit not applied");
    c_last_rail: cover property ($rose(ctl_o.rail_en[5]));
    c_refused: cover property (psel_i && penable_i && pslverr_o);
    c_shutdown: cover property ($fell(ctl_o.rail_en[5]));
endmodule // psq_ctrl_asserts

bind psq_ctrl psq_ctrl_asserts chk_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .hw_enable_pin_i(hw_enable_pin_i), .mon_i(mon_i), .bus_present_i(bus_present_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ctl_o(ctl_o));

// ===== psq_host.sv
// Host model: APB master that notes the expected answer of each read.
// Assumes an APB slave on clk_i; signals change only after rising edges.
`timescale 1ns/1ps
module psq_host (
    input wire logic clk_i,
    input wire logic pready_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o
);
    logic [64:0] exp_q[$];
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    // One transfer: setup cycle, then access held until ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) @(posedge clk_i);
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    // Read with expected value, compare mask and expected refusal
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
        input logic err);
        exp_q.push_back({err, m, e});
        xfer(1'b0, a, 32'h0);
    endtask
endmodule // psq_host

// ===== tb.sv
// Testbench: sequencing, blanking, ramp, flags and defaults of psq_ctrl.
// Assumes psq_host as register master and a 25 MHz clock.
`timescale 1ns/1ps
`include "psq_map.svh"
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, a); end end
`define WT(c, lim) begin for (n = 0; n < (lim) && !(c); n++) @(posedge sys_clk_i); \
    if (n >= (lim)) n_fail++; end
module tb;
    import psq_pkg::*;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, pin = 1'b0, bus_ok = 1'b1;
    psq_mon_t mon = '0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [64:0] e;
    psq_ctl_t ctl;
    int n_fail = 0, num_checks = 0, cyc = 0, n, t1, t5;
    always #20 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) cyc <= cyc + 1;
    psq_ctrl dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .hw_enable_pin_i(pin),
        .mon_i(mon), .bus_present_i(bus_ok), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .ctl_o(ctl));
    psq_host host_u (.clk_i(sys_clk_i), .pready_i(pready), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Oldest note against each completed read
    always @(posedge sys_clk_i) begin
        if (psel && penable && pready && !pwrite) begin
            e = host_u.exp_q.pop_front();
            `CHK("pslverr", e[64], pslverr)
            if (!e[64]) `CHK("prdata", e[31:0], prdata & e[63:32])
        end
    end
    initial begin
        repeat (97000) @(posedge sys_clk_i);
        n_fail++;
        test_done;
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        v = $urandom(32'hC5AA);
        repeat (8) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        host_u.rd(`PSQ_GEN_OFF, 32'h0, 32'hFF, 1'b0);
        host_u.rd(`PSQ_SLOT_OFF, 32'h358C8, 32'h3FFFF, 1'b0);
        host_u.rd(`PSQ_EN_OFF, 32'h80, 32'hFF, 1'b0);
        host_u.rd(8'h1C, 32'h0, 32'h0, 1'b1);
        host_u.rd(8'h02, 32'h0, 32'h0, 1'b1);
        for (int k = 0; k < 3; k++) begin
            v = $urandom | 32'h10;
            host_u.wr(`PSQ_GEN_OFF, v);
            host_u.rd(`PSQ_GEN_OFF, 32'h10, 32'hFF, 1'b0);
            if (k == 0) mon.undervoltage_lockout <= 1'b1;
            else if (k == 1) bus_ok <= 1'b0;
            else mon.thermal_shutdown <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            mon.undervoltage_lockout <= 1'b0;
            bus_ok <= 1'b1;
            mon.thermal_shutdown <= 1'b0;
            repeat (4) @(posedge sys_clk_i);
            host_u.rd(`PSQ_GEN_OFF, 32'h0, 32'hFF, 1'b0);
        end
        host_u.rd(`PSQ_FLAG_OFF, 32'h0, 32'h0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            mon.warn <= !mon.warn;
            repeat (4) @(posedge sys_clk_i);
            host_u.rd(`PSQ_STAT_OFF, 32'h4 * (1 - k), 32'hF, 1'b0);
            host_u.rd(`PSQ_FLAG_OFF, 32'h4, 32'h4, 1'b0);
        end
        host_u.rd(`PSQ_FLAG_OFF, 32'h0, 32'hF, 1'b0);
        host_u.wr(`PSQ_POL_OFF, 32'h38);
        pin <= 1'b1;
        t1 = cyc;
        repeat (4) @(posedge sys_clk_i);
        host_u.rd(`PSQ_EN_OFF, 32'h0, 32'h0, 1'b1);
        `WT(cyc >= t1 + 1400, 2000)
        host_u.rd(`PSQ_EN_OFF, 32'h80, 32'hFF, 1'b0);
        `WT(cyc >= t1 + 4000, 4000)
        `CHK("discharge", 6'h3F, ctl.discharge)
        `CHK("early rails", 6'h00, ctl.rail_en)
        // Enable every rail once bias is over; slots stagger them
        host_u.wr(`PSQ_EN_OFF, 32'hBF);
        `WT(ctl.rail_en[1], 20000)
        t1 = cyc;
        `WT(ctl.rail_en[2], 10000)
        `CHK("slot gap", 6400, cyc - t1)
        `WT(ctl.rail_en === 6'h3F, 20000)
        t5 = cyc;
        `CHK("rails up", 6'h3F, ctl.rail_en)
        `WT(ctl.buck_ref === 5'h13, 3000)
        host_u.wr(`PSQ_BUCK_OFF, 32'h517);
        `WT(ctl.buck_ref === 5'h17, 400)
        `CHK("ramp up", 1'b1, n >= 190 && n <= 270)
        host_u.wr(`PSQ_GEN_OFF, 32'h10);
        host_u.wr(`PSQ_EN_OFF, 32'h7F);
        @(posedge sys_clk_i);
        `CHK("pwm", 1'b1, ctl.buck_pwm)
        `WT(ctl.buck_ref === 5'h14, 1000)
        `CHK("ramp down", 1'b1, n >= 500 && n <= 810)
        `WT(cyc >= t5 + 52800, 60000)
        host_u.rd(`PSQ_STAT_OFF, 32'h3F0, 32'h3FF, 1'b0);
        `WT(cyc >= t5 + 56000, 5000)
        host_u.rd(`PSQ_STAT_OFF, 32'h3F1, 32'h3FF, 1'b0);
        host_u.rd(`PSQ_FLAG_OFF, 32'h1, 32'h1, 1'b0);
        host_u.rd(`PSQ_FLAG_OFF, 32'h0, 32'h1, 1'b0);
        pin <= 1'b0;
        `WT(ctl.rail_en !== 6'h3F, 8000)
        `CHK("first off", 6'h1F, ctl.rail_en)
        test_done;
    end
endmodule // tb
